/* logic/pec_proximity_emitter_config.sv */
`timescale 1ns/10ps
`include "pec_map.svh"

// Overview of operation
// - control bit 5 enables saturation indicator
// - gain: 00 x16, 10 x32, x1 x64
// - mode 0x standby, 1x active measuring
// - drive bits 7:5 set 30-100 kHz
// - drive bits 4:3 set 25-100 percent duty
// - drive bits 2:0 set peak current code
// - drive register resets to 7f, read/write
// - pulse count bits 3:0 give pulses
// - pulse count register resets to 01
// - standby: no measuring, registers still accessible
// - saturation flag reads zero unless enabled
module pec_proximity_emitter_config
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic meas_start,
  input wire logic sat_raw,
  output pec_pkg::pec_front_s front_q,
  input wire logic lk_clk,
  input wire logic lk_req,
  input wire pec_pkg::pec_access_s lk_acc,
  output logic [7:0] lk_rdata_q,
  output logic lk_done_q,
  output logic lk_busy_q
);
  import pec_pkg::*;

  typedef struct packed {
    logic busy;
    logic req_tgl;
    pec_access_s acc;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic [7:0] rdata;
    logic done;
  } pec_link_s;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [1:0] mode;
    logic [7:0] drive;
    logic [3:0] npulse;
    logic sat_s1;
    logic sat_s2;
    logic running;
    logic [3:0] left;
    logic [10:0] cnt;
    logic [10:0] period;
    logic [10:0] on;
    pec_front_s front;
  } pec_core_s;

  pec_link_s l_q, l_d;
  pec_core_s c_q, c_d;

  function automatic logic [10:0] pec_period(input logic [2:0] code);
    int khz;
    khz = `PEC_FREQ_BASE_KHZ + int'(code) * `PEC_FREQ_STEP_KHZ;
    return 11'(`PEC_REF_CLK_KHZ / khz);
  endfunction

  function automatic logic [10:0] pec_on(input logic [10:0] per,
                                         input logic [1:0] duty);
    int prod;
    prod = int'(per) * (int'(duty) + 1);
    return 11'(prod / `PEC_DUTY_QUARTERS);
  endfunction

  // link side: holds the access stable until the core answers
  always_comb
  begin
    l_d = l_q;
    l_d.done = 1'b0;
    l_d.ack_s1 = c_q.ack_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    if (lk_req && !l_q.busy)
    begin
      l_d.busy = 1'b1;
      l_d.acc = lk_acc;
      l_d.req_tgl = ~l_q.req_tgl;
    end
    if (l_q.busy && (l_q.ack_s2 != l_q.ack_seen))
    begin
      l_d.ack_seen = l_q.ack_s2;
      // core read data is held since its ack toggle, so safe to take
      l_d.rdata = c_q.rdata;
      l_d.done = 1'b1;
      l_d.busy = 1'b0;
    end
  end

  always_ff @(posedge lk_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      l_q <= '0;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  assign lk_rdata_q = l_q.rdata;
  assign lk_done_q = l_q.done;
  assign lk_busy_q = l_q.busy;

  logic acc_fire;
  logic [7:0] op_rd;
  assign acc_fire = c_q.req_s2 != c_q.req_seen;
  assign op_rd = {2'h0, c_q.front.sat_en, 1'b0,
                  c_q.front.gain == GAIN_X16 ? 2'h0 :
                  c_q.front.gain == GAIN_X32 ? 2'h2 : 2'h1,
                  c_q.mode};

  always_comb
  begin
    c_d = c_q;
    c_d.req_s1 = l_q.req_tgl;
    c_d.req_s2 = c_q.req_s1;
    c_d.sat_s1 = sat_raw;
    c_d.sat_s2 = c_q.sat_s1;
    // registers stay reachable in every mode
    if (acc_fire)
    begin
      c_d.req_seen = c_q.req_s2;
      c_d.ack_tgl = ~c_q.ack_tgl;
      if (l_q.acc.we)
      begin
        case (l_q.acc.addr)
          `PEC_OFF_OPCTL:
          begin
            // reserved positions are not stored
            c_d.front.sat_en = l_q.acc.wdata[`PEC_OPCTL_SAT_BIT];
            c_d.mode = l_q.acc.wdata[`PEC_OPCTL_MODE_HI:
                                     `PEC_OPCTL_MODE_LO];
            case (l_q.acc.wdata[`PEC_OPCTL_GAIN_HI:`PEC_OPCTL_GAIN_LO])
              2'h0: c_d.front.gain = GAIN_X16;
              2'h2: c_d.front.gain = GAIN_X32;
              default: c_d.front.gain = GAIN_X64;
            endcase
          end
          `PEC_OFF_DRIVE: c_d.drive = l_q.acc.wdata;
          // upper nibble is reserved and reads back zero
          `PEC_OFF_NPULSE:
            c_d.npulse = l_q.acc.wdata[`PEC_NP_CNT_HI:0];
          default: c_d.drive = c_q.drive;
        endcase
      end
      else
      begin
        case (l_q.acc.addr)
          `PEC_OFF_OPCTL: c_d.rdata = op_rd;
          `PEC_OFF_DRIVE: c_d.rdata = c_q.drive;
          `PEC_OFF_NPULSE: c_d.rdata = {4'h0, c_q.npulse};
          default: c_d.rdata = 8'h00;
        endcase
      end
    end
    c_d.front.active = c_d.mode[`PEC_OPCTL_MODE_HI];
    c_d.front.peak_code = c_d.drive[`PEC_DRV_CUR_HI:`PEC_DRV_CUR_LO];
    c_d.front.sat_flag = c_d.front.sat_en & c_q.sat_s2;
    // burst engine; rate and duty latched at start so a mid-burst write
    // cannot change the timing of a pulse already under way (peak code follows at once)
    if (c_q.running)
    begin
      if (c_q.cnt == c_q.period - 11'h1)
      begin
        c_d.cnt = 11'h0;
        c_d.left = c_q.left - 4'h1;
        if (c_q.left == 4'h1)
        begin
          c_d.running = 1'b0;
        end
      end
      else
      begin
        c_d.cnt = c_q.cnt + 11'h1;
      end
    end
    else if (meas_start && c_q.front.active && c_q.npulse != 4'h0)
    begin
      c_d.running = 1'b1;
      c_d.left = c_q.npulse;
      c_d.cnt = 11'h0;
      c_d.period = pec_period(
        c_q.drive[`PEC_DRV_FREQ_HI:`PEC_DRV_FREQ_LO]);
      c_d.on = pec_on(c_d.period,
        c_q.drive[`PEC_DRV_DUTY_HI:`PEC_DRV_DUTY_LO]);
    end
    if (!c_d.front.active)
    begin
      c_d.running = 1'b0;
    end
    c_d.front.emit_on = c_d.running && (c_d.cnt < c_d.on);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      c_q <= '0;
      c_q.drive <= `PEC_RST_DRIVE;
      c_q.npulse <= 4'(`PEC_RST_NPULSE);
      c_q.mode <= 2'(`PEC_RST_OPCTL);
      // front copy must agree with the register from the first edge
      c_q.front.peak_code <= 3'(`PEC_RST_DRIVE);
    end
    else if (ce)
    begin
      c_q <= c_d;
    end
  end

  assign front_q = c_q.front;

  property p_sat_gate;
    @(posedge ref_clk) disable iff (!arst_n)
      !front_q.sat_en |-> !front_q.sat_flag;
  endproperty
  a_sat_gate: assert property (p_sat_gate)
    else $error("saturation flag set while indicator disabled");
  property p_standby_dark;
    @(posedge ref_clk) disable iff (!arst_n)
      !front_q.active |-> !front_q.emit_on && !c_q.running;
  endproperty
  a_standby_dark: assert property (p_standby_dark)
    else $error("emitter pulsing in standby");
  property p_op_write;
    @(posedge ref_clk) disable iff (!arst_n)
      ce && acc_fire && l_q.acc.we && l_q.acc.addr == `PEC_OFF_OPCTL
      |=> front_q.sat_en == $past(l_q.acc.wdata[5]) &&
          front_q.active == $past(l_q.acc.wdata[1]);
  endproperty
  a_op_write: assert property (p_op_write)
    else $error("control write not applied");
  property p_gain_x64;
    @(posedge ref_clk) disable iff (!arst_n)
      ce && acc_fire && l_q.acc.we && l_q.acc.addr == `PEC_OFF_OPCTL &&
      l_q.acc.wdata[2] |=> front_q.gain == GAIN_X64;
  endproperty
  a_gain_x64: assert property (p_gain_x64)
    else $error("odd gain code did not select x64");
  property p_burst_load;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(c_q.running) |-> c_q.left == $past(c_q.npulse) &&
        c_q.left != 4'h0;
  endproperty
  a_burst_load: assert property (p_burst_load)
    else $error("burst pulse count mismatch");
  property p_period;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(c_q.running) |-> c_q.period == 11'(`PEC_REF_CLK_KHZ /
        (`PEC_FREQ_BASE_KHZ +
         `PEC_FREQ_STEP_KHZ * $past(c_q.drive[7:5])));
  endproperty
  a_period: assert property (p_period)
    else $error("pulse period does not match frequency code");
  property p_duty;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(c_q.running) |-> c_q.on == 11'(int'(c_q.period) *
        (int'($past(c_q.drive[4:3])) + 1) / `PEC_DUTY_QUARTERS);
  endproperty
  a_duty: assert property (p_duty)
    else $error("on time does not match duty code");
  property p_ack;
    @(posedge ref_clk) disable iff (!arst_n)
      ce && acc_fire |=> c_q.ack_tgl != $past(c_q.ack_tgl);
  endproperty
  a_ack: assert property (p_ack)
    else $error("register access not answered");

  property p_peak;
    @(posedge ref_clk) disable iff (!arst_n)
      front_q.peak_code == c_q.drive[2:0];
  endproperty
  a_peak: assert property (p_peak)
    else $error("peak current code differs from register");

  c_burst: cover property (@(posedge ref_clk) $rose(c_q.running));
  c_opw: cover property (@(posedge ref_clk)
    acc_fire && l_q.acc.we && l_q.acc.addr == `PEC_OFF_OPCTL);
  c_sat: cover property (@(posedge ref_clk) $rose(front_q.sat_flag));
endmodule

/* pkg/pec_map.svh */
`ifndef PEC_MAP_SVH
`define PEC_MAP_SVH

`define PEC_OFF_OPCTL 8'h81
`define PEC_OFF_DRIVE 8'h82
`define PEC_OFF_NPULSE 8'h83

`define PEC_OPCTL_SAT_BIT 5
`define PEC_OPCTL_GAIN_HI 3
`define PEC_OPCTL_GAIN_LO 2
`define PEC_OPCTL_MODE_HI 1
`define PEC_OPCTL_MODE_LO 0
`define PEC_DRV_FREQ_HI 7
`define PEC_DRV_FREQ_LO 5
`define PEC_DRV_DUTY_HI 4
`define PEC_DRV_DUTY_LO 3
`define PEC_DRV_CUR_HI 2
`define PEC_DRV_CUR_LO 0
`define PEC_NP_CNT_HI 3

`define PEC_RST_OPCTL 8'h00
`define PEC_RST_DRIVE 8'h7f
`define PEC_RST_NPULSE 8'h01

`define PEC_REF_CLK_KHZ 40000
`define PEC_FREQ_BASE_KHZ 30
`define PEC_FREQ_STEP_KHZ 10
`define PEC_DUTY_QUARTERS 4

`endif

/* pkg/pec_pkg.sv */
package pec_pkg;

  typedef enum logic [1:0] {
    GAIN_X16,
    GAIN_X32,
    GAIN_X64
  } pec_gain_e;

  typedef struct packed {
    logic active;
    pec_gain_e gain;
    logic sat_en;
    logic sat_flag;
    logic emit_on;
    logic [2:0] peak_code;
  } pec_front_s;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pec_access_s;

endpackage

/* verification/pec_host_model.sv */
`timescale 1ns/10ps
`include "pec_map.svh"
module pec_host_model
(
  input wire logic lk_clk,
  output logic lk_req,
  output pec_pkg::pec_access_s lk_acc,
  input wire logic [7:0] lk_rdata_q,
  input wire logic lk_done_q
);
  import pec_pkg::*;
  initial
  begin
    lk_req = 1'b0;
    lk_acc = '0;
  end
  task automatic xfer(input logic we, input logic [7:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata,
                      output bit ok);
    logic [7:0] wd;
    int n;
    wd = wdata;
    if (addr == `PEC_OFF_OPCTL)
      wd = wdata & 8'h2f;
    if (addr == `PEC_OFF_NPULSE)
      wd = wdata & 8'h0f;
    @(posedge lk_clk);
    lk_req <= 1'b1;
    lk_acc <= '{we, addr, wd};
    @(posedge lk_clk);
    lk_req <= 1'b0;
    // released lines must not keep showing the old request
    lk_acc <= ~lk_acc;
    ok = 0;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge lk_clk);
      if (lk_done_q === 1'b1)
        ok = 1;
    end
    rdata = lk_rdata_q;
  endtask
endmodule

/* verification/tb_proximity_emitter_config.sv */
`timescale 1ns/10ps
`include "pec_map.svh"
module tb_proximity_emitter_config;
  import pec_pkg::*;
  logic ref_clk = 1'b0;
  logic lk_clk;
  logic arst_n, ce, meas_start, sat_raw, lk_req, lk_done_q, lk_busy_q;
  pec_front_s front_q;
  pec_access_s lk_acc;
  logic [7:0] lk_rdata_q;
  int fails = 0;
  int total_checks = 0;
  int pl, ol;

  always #12.5 ref_clk = ~ref_clk;
  // link clock slower and offset so its edges drift against the core clock
  initial
  begin
    lk_clk = 1'b0;
    #4;
    forever #15 lk_clk = ~lk_clk;
  end

  pec_proximity_emitter_config pec_proximity_emitter_config_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
    .meas_start(meas_start), .sat_raw(sat_raw), .front_q(front_q),
    .lk_clk(lk_clk), .lk_req(lk_req), .lk_acc(lk_acc),
    .lk_rdata_q(lk_rdata_q), .lk_done_q(lk_done_q), .lk_busy_q(lk_busy_q));

  pec_host_model pec_host_model_inst (
    .lk_clk(lk_clk), .lk_req(lk_req), .lk_acc(lk_acc),
    .lk_rdata_q(lk_rdata_q), .lk_done_q(lk_done_q));

  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic we, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    bit ok;
    pec_host_model_inst.xfer(we, a, d, r, ok);
    if (!ok)
    begin
      fails++;
      $display("mismatch at %0t: access never completed", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask

  // counts rising edges of the emitter and the width of the first one
  task automatic burst(output int pulses, output int on_len);
    logic prev;
    pulses = 0;
    on_len = 0;
    prev = 1'b0;
    @(posedge ref_clk);
    meas_start <= 1'b1;
    @(posedge ref_clk);
    meas_start <= 1'b0;
    repeat (1300)
    begin
      @(posedge ref_clk);
      if (front_q.emit_on === 1'b1 && !prev)
        pulses++;
      if (front_q.emit_on === 1'b1 && pulses == 1)
        on_len++;
      prev = (front_q.emit_on === 1'b1);
    end
  endtask

  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    meas_start = 1'b0;
    sat_raw = 1'b0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({7'h0, front_q.active}, 8'h00);
    check({5'h0, front_q.peak_code}, 8'h07);
    rd(`PEC_OFF_OPCTL, `PEC_RST_OPCTL);
    rd(`PEC_OFF_DRIVE, `PEC_RST_DRIVE);
    rd(`PEC_OFF_NPULSE, `PEC_RST_NPULSE);
    for (int m = 0; m < 4; m++)
    begin
      wr(`PEC_OFF_OPCTL, 8'(m));
      check({7'h0, front_q.active}, {7'h0, m[1]});
      rd(`PEC_OFF_OPCTL, 8'(m));
    end
    for (int g = 0; g < 4; g++)
    begin
      wr(`PEC_OFF_OPCTL, 8'(g << 2));
      check({6'h0, front_q.gain},
            {6'h0, g == 0 ? GAIN_X16 : g == 2 ? GAIN_X32 : GAIN_X64});
      rd(`PEC_OFF_OPCTL, g == 3 ? 8'h04 : 8'(g << 2));
    end
    wr(`PEC_OFF_DRIVE, 8'ha5);
    // third link edge of the access: taken one edge ago, not yet answered
    fork
      rd(`PEC_OFF_DRIVE, 8'ha5);
      begin
        repeat (3) @(posedge lk_clk);
        check({7'h0, lk_busy_q}, 8'h01);
      end
    join
    check({5'h0, front_q.peak_code}, 8'h05);
    wr(`PEC_OFF_NPULSE, 8'h0f);
    rd(`PEC_OFF_NPULSE, 8'h0f);
    rd(8'h80, 8'h00);
    wr(`PEC_OFF_OPCTL, 8'h20);
    sat_raw <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check({7'h0, front_q.sat_flag}, 8'h01);
    rd(`PEC_OFF_OPCTL, 8'h20);
    wr(`PEC_OFF_OPCTL, 8'h00);
    repeat (5) @(posedge ref_clk);
    check({7'h0, front_q.sat_flag}, 8'h00);
    // fastest rate, half duty, lowest current, two pulses
    wr(`PEC_OFF_DRIVE, 8'he8);
    wr(`PEC_OFF_NPULSE, 8'h02);
    burst(pl, ol);
    check(pl[7:0], 8'h00);
    wr(`PEC_OFF_OPCTL, 8'h02);
    check({5'h0, front_q.peak_code}, 8'h00);
    burst(pl, ol);
    check(pl[7:0], 8'h02);
    check(ol[7:0], 8'((`PEC_REF_CLK_KHZ / (`PEC_FREQ_BASE_KHZ
          + `PEC_FREQ_STEP_KHZ * 7)) * 2 / 4));
    // reserved count code fires nothing
    wr(`PEC_OFF_NPULSE, 8'h00);
    rd(`PEC_OFF_NPULSE, 8'h00);
    burst(pl, ol);
    check(pl[7:0], 8'h00);
    final_report();
  end
endmodule
